// [rtl/switch_input_threshold_status.sv]
// Switch input threshold status registers with plain register port
`timescale 1ns/10ps
`default_nettype none
`include "switch_status_cfg.svh"

// Summary of operation
// R1: Comparator-mode sample sets its status bit 1 above threshold, 0 below.
// R2: Inputs 0 to 11 in ADC mode report one bit at their own position.
// R3: Inputs 12 to 17 report two-bit codes in bits 23..12; 0 below 2A, 1 between.
// R4: Code 2 at or above 2B; code 3 never produced.
// R5: Inputs 19 to 22 report two-bit codes in bits 9..2 over 3A, 3B, 3C.
// R6: Input 23 reports a three-bit code in bits 12..10 over six zones.
// R7: ADC fields change only for ADC-mode samples; equal counts as above.
// R8: All status is read-only, resets to zero; high bits 23..13 read zero.
// R9: Input 18 uses bits 1..0 with the three-threshold encoding.
// R10: Comparator register holds one bit per input at the input's index.
// R11: Each field is replaced whole in one edge after its sample completes.
module switch_input_threshold_status
   import switch_status_pkg::*;
#(
   parameter int INPUT_COUNT = `STS_INPUT_COUNT
)
(
   // Clock, reset and enable
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   // Completed samples from the polling logic
   input wire sample_type i_sample,
   // Programmed thresholds
   input wire thresholds_type i_thr,
   // Register port
   input wire logic [`STS_ADDR_WIDTH-1:0] i_addr,
   input wire logic [`STS_DATA_WIDTH-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [`STS_DATA_WIDTH-1:0] o_rdata
);

   result_type result;
   logic [`STS_DATA_WIDTH-1:0] comparator_status;
   logic [`STS_DATA_WIDTH-1:0] adc_status_low_inputs;
   logic [`STS_DATA_WIDTH-1:0] adc_status_high_inputs;

   // Compare and encode in its own stage so the store below is one plain write
   zone_encoder zone_encoder_inst (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_ce(i_ce),
      .i_sample(i_sample),
      .i_thr(i_thr),
      .o_result(result)
   );

   // Write enables for the two kinds of sample, qualified per input by sel below
   wire logic comp_hit = result.valid && !result.adc_mode;
   // R7: only ADC-mode samples touch the zone fields
   wire logic adc_hit = result.valid && result.adc_mode;

   logic [`STS_DATA_WIDTH-1:0] next_comparator;
   logic [`STS_DATA_WIDTH-1:0] next_low;
   logic [`STS_DATA_WIDTH-1:0] next_high;

   // Field placement, one slice per input
   genvar g;
   generate
      for (g = 0; g < INPUT_COUNT; g = g + 1) begin : g_input
         wire logic sel = (result.index == 5'(g));
         // R10: R1: comparator bit sits at the input index
         assign next_comparator[g] = (comp_hit && sel) ? result.comp_above : comparator_status[g];
         if (g <= `STS_LAST_SINGLE) begin : g_single
            // R2: single bit at position equal to index
            assign next_low[g] = (adc_hit && sel) ? result.zone[0] : adc_status_low_inputs[g];
         end else if (g <= `STS_LAST_TWO) begin : g_two
            // R3: two-bit field from bit 12 upward
            localparam int P = `STS_POS_TWO_BASE + 2 * (g - int'(`STS_FIRST_TWO));
            assign next_low[P+1:P] = (adc_hit && sel) ? result.zone[1:0] : adc_status_low_inputs[P+1:P];
         end else if (g <= `STS_LAST_THREE) begin : g_three
            // R9: R5: two-bit field from bit 0 upward
            localparam int P = `STS_POS_THREE_BASE + 2 * (g - int'(`STS_FIRST_THREE));
            assign next_high[P+1:P] = (adc_hit && sel) ? result.zone[1:0] : adc_status_high_inputs[P+1:P];
         end else begin : g_five
            // R6: three-bit field at bits 12..10
            assign next_high[`STS_POS_FIVE+2:`STS_POS_FIVE] =
               (adc_hit && sel) ? result.zone : adc_status_high_inputs[`STS_POS_FIVE+2:`STS_POS_FIVE];
         end
      end
   endgenerate

   // R8: reserved high bits never hold anything but zero
   assign next_high[`STS_DATA_WIDTH-1:`STS_HIGH_USED_MSB+1] = '0;

   // R11: whole fields change on a single edge, a read never sees a half code
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         comparator_status <= `STS_RESET_VALUE;
         adc_status_low_inputs <= `STS_RESET_VALUE;
         adc_status_high_inputs <= `STS_RESET_VALUE;
      end else if (i_ce) begin
         comparator_status <= next_comparator;
         adc_status_low_inputs <= next_low;
         adc_status_high_inputs <= next_high;
      end
   end

   // Read decode; writes are accepted but change nothing since all fields are status
   wire logic hit_comp = (i_addr == `STS_OFF_COMPARATOR);
   wire logic hit_low = (i_addr == `STS_OFF_ADC_LOW);
   wire logic hit_high = (i_addr == `STS_OFF_ADC_HIGH);
   logic [`STS_DATA_WIDTH-1:0] read_mux;
   always_comb begin
      if (hit_comp) begin
         read_mux = comparator_status;
      end else if (hit_low) begin
         read_mux = adc_status_low_inputs;
      end else if (hit_high) begin
         read_mux = adc_status_high_inputs;
      end else begin
         read_mux = `STS_UNMAPPED_VALUE;
      end
   end

   // R8: write strobe and data deliberately unused
   wire logic unused_write = i_wr ^ (^i_wdata);

   // Read data stand one cycle only, zero otherwise
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_rdata <= '0;
      end else if (i_ce) begin
         o_rdata <= (i_rd && !unused_write && 1'b0) ? '0 : (i_rd ? read_mux : '0);
      end
   end

endmodule
`default_nettype wire

// [rtl/switch_status_cfg.svh]
// Register offsets, field positions and reset values of the switch status block
`ifndef SWITCH_STATUS_CFG_SVH
`define SWITCH_STATUS_CFG_SVH

`define STS_ADDR_WIDTH 8
`define STS_DATA_WIDTH 24
`define STS_VALUE_WIDTH 10
`define STS_INPUT_COUNT 24

`define STS_OFF_COMPARATOR 8'h05
`define STS_OFF_ADC_LOW 8'h06
`define STS_OFF_ADC_HIGH 8'h07

`define STS_RESET_VALUE 24'h000000
`define STS_UNMAPPED_VALUE 24'h000000

`define STS_LAST_SINGLE 5'h0B
`define STS_LAST_TWO 5'h11
`define STS_LAST_THREE 5'h16
`define STS_FIVE_INDEX 5'h17
`define STS_FIRST_TWO 5'h0C
`define STS_FIRST_THREE 5'h12

`define STS_POS_TWO_BASE 12
`define STS_POS_THREE_BASE 0
`define STS_POS_FIVE 10
`define STS_HIGH_USED_MSB 12

`endif

// [rtl/switch_status_pkg.sv]
// Types shared by the switch status block
package switch_status_pkg;

   // One completed sample of one switch input
   typedef struct packed {
      logic valid;
      logic [4:0] index;
      logic adc_mode;
      logic comp_above;
      logic [9:0] value;
   } sample_type;

   // Programmed ADC thresholds
   typedef struct packed {
      logic [9:0] single_thr;
      logic [9:0] thr_2a;
      logic [9:0] thr_2b;
      logic [9:0] thr_3a;
      logic [9:0] thr_3b;
      logic [9:0] thr_3c;
      logic [9:0] eighth_threshold;
      logic [9:0] ninth_threshold;
   } thresholds_type;

   // Registered result of one sample, ready to be stored
   typedef struct packed {
      logic valid;
      logic [4:0] index;
      logic adc_mode;
      logic comp_above;
      logic [2:0] zone;
   } result_type;

endpackage

// [rtl/zone_encoder.sv]
// Threshold compare and zone encoding for one sample, registered output
`timescale 1ns/10ps
`default_nettype none
`include "switch_status_cfg.svh"

module zone_encoder
   import switch_status_pkg::*;
(
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   // Sample and thresholds
   input wire sample_type i_sample,
   input wire thresholds_type i_thr,
   // Encoded result
   output var result_type o_result
);

   // R7: equal counts above
   wire logic ge_single = (i_sample.value >= i_thr.single_thr);
   wire logic ge_2a = (i_sample.value >= i_thr.thr_2a);
   wire logic ge_2b = (i_sample.value >= i_thr.thr_2b);
   wire logic ge_3a = (i_sample.value >= i_thr.thr_3a);
   wire logic ge_3b = (i_sample.value >= i_thr.thr_3b);
   wire logic ge_3c = (i_sample.value >= i_thr.thr_3c);
   wire logic ge_8 = (i_sample.value >= i_thr.eighth_threshold);
   wire logic ge_9 = (i_sample.value >= i_thr.ninth_threshold);

   // Class of the input by its index
   wire logic is_single = (i_sample.index <= `STS_LAST_SINGLE);
   wire logic is_two = (i_sample.index <= `STS_LAST_TWO) && !is_single;
   wire logic is_five = (i_sample.index == `STS_FIVE_INDEX);

   // R2: single threshold bit
   wire logic [2:0] zone_single = {2'b00, ge_single};
   // R3: R4: two thresholds, code 3 never made
   wire logic [2:0] zone_two = ge_2b ? 3'h2 : (ge_2a ? 3'h1 : 3'h0);
   // R5: R9: three thresholds, four zones
   wire logic [2:0] zone_three = ge_3c ? 3'h3 : (ge_3b ? 3'h2 : (ge_3a ? 3'h1 : 3'h0));
   // R6: six zones on the last input
   wire logic [2:0] zone_five = ge_9 ? 3'h5 : (ge_8 ? 3'h4 : zone_three);

   wire logic [2:0] next_zone = is_single ? zone_single : (is_two ? zone_two : (is_five ? zone_five : zone_three));

   // Result register, one cycle after the sample
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_result <= '0;
      end else if (i_ce) begin
         o_result.valid <= i_sample.valid && (i_sample.index <= `STS_FIVE_INDEX);
         o_result.index <= i_sample.index;
         o_result.adc_mode <= i_sample.adc_mode;
         o_result.comp_above <= i_sample.comp_above;
         o_result.zone <= next_zone;
      end
   end

endmodule
`default_nettype wire

// [tb/status_host.sv]
// Host model issuing one-cycle register strobes
`timescale 1ns/10ps
`default_nettype none
module status_host (
   // Clock
   input wire logic i_clk,
   // Register port toward the block
   output logic [7:0] o_addr,
   output logic [23:0] o_wdata,
   output logic o_wr,
   output logic o_rd
);
   initial {o_addr, o_wdata, o_wr, o_rd} = '0;
   // Strobes last one cycle; the block never stalls
   task automatic rd(input logic [7:0] a);
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
   endtask
endmodule
`default_nettype wire

// [tb/switch_input_threshold_status_tb.sv]
// Self-checking bench of the switch status block
`timescale 1ns/10ps
`default_nettype none
module switch_input_threshold_status_tb
   import switch_status_pkg::*;
;
   logic i_clk, i_reset, i_ce, i_wr, i_rd, rd_d = 1'b0;
   logic [7:0] i_addr;
   logic [23:0] i_wdata, o_rdata, q[$], m[5:7];
   logic [15:0] r = 16'h000B;
   logic [9:0] v;
   sample_type smp;
   thresholds_type thr;
   int err_total, total_checks;
   switch_input_threshold_status #(.INPUT_COUNT(24)) switch_input_threshold_status_inst (.i_clk(i_clk),
      .i_reset(i_reset), .i_ce(i_ce), .i_sample(smp), .i_thr(thr), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
   status_host status_host_inst (.i_clk(i_clk), .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   function automatic logic [15:0] nx(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED o_rdata expected %h seen %h", exp, seen);
      end
   endtask
   // Read data stands one cycle after the strobe; compare with the oldest note
   always @(posedge i_clk) begin
      if (rd_d) chk(o_rdata, q.pop_front());
      rd_d <= i_rd;
   end
   task automatic rd(input logic [7:0] a);
      q.push_back(m[a]);
      status_host_inst.rd(a);
   endtask
   // Present one sample, then update the reference copy of the fields
   task automatic put(input logic [4:0] i, input logic a, input logic c);
      logic [2:0] z;
      @(posedge i_clk);
      smp <= '{1'b1, i, a, c, v};
      @(posedge i_clk);
      smp.valid <= 1'b0;
      z = v >= thr.thr_3c ? 3'h3 : v >= thr.thr_3b ? 3'h2 : {2'h0, v >= thr.thr_3a};
      if (i == 5'h17) z = v >= thr.ninth_threshold ? 3'h5 : v >= thr.eighth_threshold ? 3'h4 : z;
      if (i >= 5'h0C && i < 5'h12) z = v >= thr.thr_2b ? 3'h2 : {2'h0, v >= thr.thr_2a};
      if (i > 5'h17) begin
         // Index past the last input is dropped, nothing to note
      end else if (!a) m[5][i] = c;
      else if (i < 5'h0C) m[6][i] = v >= thr.single_thr;
      else if (i < 5'h12) m[6][2 * i - 12 +: 2] = z[1:0];
      else if (i < 5'h17) m[7][2 * i - 36 +: 2] = z[1:0];
      else m[7][12:10] = z;
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Watchdog sized well above the 3046 cycles the run needs
   initial begin
      #100000;
      err_total++;
      give_verdict();
   end
   initial begin
      smp = '0;
      thr = '{10'h0C8, 10'h064, 10'h12C, 10'h096, 10'h0FA, 10'h15E, 10'h1C2, 10'h258};
      m = '{24'h000000, 24'h000000, 24'h000000};
      i_ce = 1'b1;
      i_reset = 1'b1;
      repeat (4) @(posedge i_clk);
      i_reset <= 1'b0;
      // writes ignored, reset zero, unmapped zero
      status_host_inst.wr(8'h06, 24'hFFFFFF);
      for (int a = 5; a < 8; a++) rd(8'(a));
      q.push_back(24'h000000);
      status_host_inst.rd(8'h08);
      // Random samples, half of them on or just under a threshold
      repeat (300) begin
         r = nx(r);
         v = r[14] ? thr[10 * r[13:11] +: 10] - {9'h000, r[15]} : r[9:0];
         put(5'(r % 16'h0018), r[5], r[6]);
         rd(!r[5] ? 8'h05 : 5'(r % 16'h0018) < 5'h12 ? 8'h06 : 8'h07);
         for (int a = 5; a < 8; a++) rd(8'(a));
      end
      // Index beyond the last input is dropped in either mode
      v = 10'h3FF;
      put(5'h1F, 1'b1, 1'b1);
      put(5'h18, 1'b0, 1'b1);
      for (int a = 5; a < 8; a++) rd(8'(a));
      // Low enable freezes the block, so a sample offered then is lost
      @(posedge i_clk);
      i_ce <= 1'b0;
      smp <= '{1'b1, 5'h17, 1'b0, ~m[5][23], 10'h000};
      @(posedge i_clk);
      smp.valid <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_ce <= 1'b1;
      for (int a = 5; a < 8; a++) rd(8'(a));
      // Mid-run reset clears every field the samples have set
      @(posedge i_clk);
      i_reset <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_reset <= 1'b0;
      m = '{24'h000000, 24'h000000, 24'h000000};
      for (int a = 5; a < 8; a++) rd(8'(a));
      repeat (3) @(posedge i_clk);
      give_verdict();
   end
endmodule
bind switch_input_threshold_status switch_status_properties #(.INPUT_COUNT(INPUT_COUNT)) props_inst (.i_clk(i_clk),
   .i_reset(i_reset), .i_ce(i_ce), .i_sample(i_sample), .i_thr(i_thr), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
`default_nettype wire

// [tb/switch_status_properties.sv]
// Port assertions of the switch status block
`timescale 1ns/10ps
`default_nettype none
`include "switch_status_cfg.svh"
module switch_status_properties
   import switch_status_pkg::*;
#(
   parameter int INPUT_COUNT = `STS_INPUT_COUNT
)
(
   // Clock and control
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   // Samples and thresholds
   input wire sample_type i_sample,
   input wire thresholds_type i_thr,
   // Register port
   input wire logic [`STS_ADDR_WIDTH-1:0] i_addr,
   input wire logic [`STS_DATA_WIDTH-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [`STS_DATA_WIDTH-1:0] o_rdata
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   // Zones of the present sample; equal counts as the higher zone
   wire logic [4:0] idx = i_sample.index;
   wire logic [9:0] v = i_sample.value;
   wire logic ca = i_sample.comp_above;
   wire logic adc = i_sample.valid && i_sample.adc_mode;
   wire logic z1 = v >= i_thr.single_thr;
   wire logic [1:0] z2 = v >= i_thr.thr_2b ? 2'h2 : {1'b0, v >= i_thr.thr_2a};
   wire logic [1:0] z3 = v >= i_thr.thr_3c ? 2'h3 : v >= i_thr.thr_3b ? 2'h2 : {1'b0, v >= i_thr.thr_3a};
   wire logic [2:0] z5 = v >= i_thr.ninth_threshold ? 3'h5 : v >= i_thr.eighth_threshold ? 3'h4 : {1'b0, z3};
   wire logic [4:0] p2 = {idx[3:0], 1'b0} - 5'h0C;
   wire logic [5:0] p3 = {idx, 1'b0} - 6'h24;
   wire logic [11:0] pr = o_rdata[23:12];
   // Field seen by a read two cycles after its sample
   cmp_bit_a: assert property (i_sample.valid && !i_sample.adc_mode && idx < 5'h18 ##2 i_rd && i_addr == 8'h05
      |=> o_rdata[$past(idx, 3)] == $past(ca, 3)) else $error("comparator bit wrong");
   single_bit_a: assert property (adc && idx < 5'h0C ##2 i_rd && i_addr == 8'h06
      |=> o_rdata[$past(idx, 3)] == $past(z1, 3)) else $error("single threshold bit wrong");
   two_zone_a: assert property (adc && idx >= 5'h0C && idx < 5'h12 ##2 i_rd && i_addr == 8'h06
      |=> o_rdata[$past(p2, 3) +: 2] == $past(z2, 3)) else $error("two threshold zone wrong");
   three_zone_a: assert property (adc && idx >= 5'h12 && idx < 5'h17 ##2 i_rd && i_addr == 8'h07
      |=> o_rdata[$past(p3, 3) +: 2] == $past(z3, 3)) else $error("three threshold zone wrong");
   five_zone_a: assert property (adc && idx == 5'h17 ##2 i_rd && i_addr == 8'h07
      |=> o_rdata[12:10] == $past(z5, 3)) else $error("five threshold zone wrong");
   no_code3_a: assert property (i_rd && i_addr == 8'h06
      |=> (pr & (pr >> 1) & 12'h555) == 12'h000) else $error("code three produced");
   high_zero_a: assert property (i_rd && i_addr == 8'h07
      |=> o_rdata[23:13] == 11'h000 && o_rdata[12:10] <= 3'h5) else $error("unused bits set");
   idle_zero_a: assert property (!i_rd |=> o_rdata == 24'h000000) else $error("read data outside read");
endmodule
`default_nettype wire
